// >>> rtl/spqc_params.svh
// Purpose: Constants of the scaled pulse and quadrature counter.
// Assumes: A 40 MHz clock and a word-indexed register port.
// Notes: Offsets are word indices on the plain register port.
`ifndef SPQC_PARAMS_SVH
`define SPQC_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SPQC_OFF_CTRL 4'h0
`define SPQC_OFF_MUL 4'h1
`define SPQC_OFF_DIV 4'h2
`define SPQC_OFF_BASE 4'h3
`define SPQC_OFF_THR0 4'h4
`define SPQC_OFF_THR1 4'h5
`define SPQC_OFF_RAW 4'h6
`define SPQC_OFF_RESULT 4'h7
`define SPQC_OFF_STAT 4'h8
`define SPQC_OFF_MASK 4'h9
`define SPQC_OFF_PRESET 4'ha
`define SPQC_OFF_VIEW 4'hb

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define SPQC_CTRL_FUNC_LSB 0
`define SPQC_CTRL_POLICY_BIT 2
`define SPQC_CTRL_AUXDIR_BIT 3
`define SPQC_CTRL_BATCH_BIT 4
`define SPQC_CTRL_RST 32'h0000_0000
`define SPQC_MUL_RST 32'h0000_0001
`define SPQC_DIV_RST 32'h0000_0001
`define SPQC_BASE_RST 32'h0000_0000
`define SPQC_STAT_W 4
`define SPQC_ST_ZERO 0
`define SPQC_ST_OVF 1
`define SPQC_ST_UNF 2
`define SPQC_ST_MENU 3

// ****************************************************************
// Display limits and times
// ****************************************************************
`define SPQC_LIMIT_HI 64'sd999999
`define SPQC_LIMIT_LO -64'sd99999
`define SPQC_CLK_HZ 40000000
`define SPQC_QUICK_MS 5000
`define SPQC_HOLD_MS 2000
`define SPQC_QUICK_CYC ((`SPQC_QUICK_MS / 1000) * `SPQC_CLK_HZ)
`define SPQC_HOLD_CYC ((`SPQC_HOLD_MS / 1000) * `SPQC_CLK_HZ)
`define SPQC_ID_CYC 1000
`define SPQC_ALT_CYC 2000

`endif

// >>> rtl/spqc_pkg.sv
// Purpose: Types of the scaled pulse and quadrature counter.
// Assumes: Included constants in spqc_params.svh.
// Notes: Register port and keys travel as packed structs.
package spqc_pkg;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [1:0] {FN_SUM, FN_DIFF, FN_QUAD1, FN_QUAD4} spqc_func_t;

  typedef enum {ST_ID, ST_RESTORE, ST_MEASURE, ST_CONFIRM, ST_QUICK, ST_MENU,
    ST_EDIT} spqc_state_t;

  typedef enum logic [2:0] {SH_ID, SH_VALUE, SH_OVF, SH_UNF, SH_NAME, SH_ITEM,
    SH_MENU, SH_CONFIRM} spqc_show_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } spqc_bus_t;

  typedef struct packed {
    logic esc;
    logic enter;
    logic up;
    logic down;
    logic reset;
  } spqc_keys_t;

endpackage

// >>> rtl/spqc_counter.sv
// Purpose: Counting, scaling, zeroing and front panel core of a panel counter.
// Assumes: Inputs and keys are synchronous to CLK; keys other than ESC are one-cycle presses.
// Notes: ESC is a level so that its hold time can be measured.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "spqc_params.svh"

module spqc_counter #(
  parameter int QUICK_CYC = `SPQC_QUICK_CYC,
  parameter int HOLD_CYC = `SPQC_HOLD_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire spqc_pkg::spqc_bus_t BUS,
  output logic [31:0] RD_DATA,
  input wire logic IN_A,
  input wire logic IN_B,
  input wire logic IN_AUX,
  input wire logic IN_ZERO,
  input wire spqc_pkg::spqc_keys_t KEYS,
  input wire logic NV_VALID,
  input wire logic [31:0] NV_COUNT,
  output spqc_pkg::spqc_show_t SHOW,
  output logic [31:0] DISP_VALUE,
  output logic [1:0] DISP_ITEM,
  output logic MENU_OPEN,
  output logic IRQ
);
  import spqc_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] mul_reg;
  logic [31:0] div_reg;
  logic [31:0] base_reg;
  logic [31:0] thr0_reg;
  logic [31:0] thr1_reg;
  logic [31:0] act_mul_reg;
  logic [31:0] act_div_reg;
  logic [31:0] act_base_reg;
  logic [31:0] raw_reg;
  logic [31:0] raw_next;
  logic [`SPQC_STAT_W-1:0] stat_reg;
  logic [`SPQC_STAT_W-1:0] mask_reg;
  logic [31:0] rd_reg;
  logic a_reg;
  logic b_reg;
  logic ovf_reg;
  logic unf_reg;
  logic irq_reg;
  spqc_state_t state_reg;
  spqc_state_t state_next;
  logic [31:0] timer_reg;
  logic [31:0] hold_reg;
  logic [31:0] alt_reg;
  logic name_reg;
  logic [1:0] item_reg;
  logic [1:0] item_next;
  logic [31:0] edit_reg;
  spqc_show_t show_reg;
  logic [31:0] disp_reg;
  logic menu_reg;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire spqc_func_t func = spqc_func_t'(ctrl_reg[`SPQC_CTRL_FUNC_LSB +: 2]);
  wire policy_now = ctrl_reg[`SPQC_CTRL_POLICY_BIT];
  wire aux_dir_role = ctrl_reg[`SPQC_CTRL_AUXDIR_BIT];
  wire batcher = ctrl_reg[`SPQC_CTRL_BATCH_BIT];
  wire wr_ctrl = BUS.wr && (BUS.addr == `SPQC_OFF_CTRL);
  wire wr_mul = BUS.wr && (BUS.addr == `SPQC_OFF_MUL);
  wire wr_div = BUS.wr && (BUS.addr == `SPQC_OFF_DIV);
  wire wr_base = BUS.wr && (BUS.addr == `SPQC_OFF_BASE);
  wire wr_thr0 = BUS.wr && (BUS.addr == `SPQC_OFF_THR0);
  wire wr_thr1 = BUS.wr && (BUS.addr == `SPQC_OFF_THR1);
  wire wr_stat = BUS.wr && (BUS.addr == `SPQC_OFF_STAT);
  wire wr_mask = BUS.wr && (BUS.addr == `SPQC_OFF_MASK);
  wire wr_preset = BUS.wr && (BUS.addr == `SPQC_OFF_PRESET);

  // ****************************************************************
  // Zeroing sources
  // ****************************************************************
  wire key_zero = (state_reg == ST_CONFIRM) && KEYS.enter;
  wire restore = (state_reg == ST_RESTORE);
  wire zero_now = IN_ZERO || wr_preset || key_zero;
  wire edit_commit = (state_reg == ST_EDIT) && KEYS.enter;
  wire apply_set = policy_now || zero_now || restore;

  // ****************************************************************
  // Pulse and quadrature decode
  // ****************************************************************
  wire a_rise = IN_A && !a_reg;
  wire b_rise = IN_B && !b_reg;
  wire a_edge = IN_A ^ a_reg;
  wire b_edge = IN_B ^ b_reg;
  wire dir_down = aux_dir_role && IN_AUX;
  wire q4_fwd = IN_A ^ b_reg;
  wire q4_step = a_edge ^ b_edge;
  logic signed [31:0] delta;

  always_comb
  begin
    delta = 32'sh0;
    case (func)
      FN_SUM: delta = 32'(a_rise) + 32'(b_rise);
      FN_DIFF: delta = 32'(a_rise) - 32'(b_rise);
      FN_QUAD1:
      begin
        if (a_rise)
          delta = IN_B ? -32'sh1 : 32'sh1;
        else
          delta = 32'sh0;
      end
      FN_QUAD4:
      begin
        if (q4_step)
          delta = q4_fwd ? 32'sh1 : -32'sh1;
        else
          delta = 32'sh0;
      end
      default: delta = 32'sh0;
    endcase
    if (dir_down)
      delta = -delta;
  end

  assign raw_next = zero_now ? 32'h0 : (restore && NV_VALID) ? NV_COUNT : raw_reg + delta;

  // ****************************************************************
  // Scaling and range check
  // ****************************************************************
  wire [31:0] div_safe = (act_div_reg == 32'h0) ? 32'h1 : act_div_reg;
  wire signed [63:0] product = 64'(signed'(raw_reg)) * 64'(signed'(act_mul_reg));
  wire signed [63:0] scaled = product / 64'(signed'(div_safe));
  wire signed [63:0] result = scaled + 64'(signed'(act_base_reg));
  wire over = result > `SPQC_LIMIT_HI;
  wire under = result < `SPQC_LIMIT_LO;

  // ****************************************************************
  // Quick view items
  // ****************************************************************
  wire [1:0] first_item = batcher ? 2'h0 : 2'h1;
  wire [31:0] item_value = (item_reg == 2'h0) ? base_reg :
    (item_reg == 2'h1) ? thr0_reg : thr1_reg;
  wire quick_step = KEYS.up || KEYS.down;
  wire esc_held = hold_reg >= 32'(HOLD_CYC - 1);

  always_comb
  begin
    item_next = item_reg;
    if (item_reg == 2'h2)
      item_next = first_item;
    else
      item_next = item_reg + 2'h1;
  end

  // ****************************************************************
  // Front panel state machine
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_ID:
        if (timer_reg >= 32'(`SPQC_ID_CYC - 1))
          state_next = ST_RESTORE;
      ST_RESTORE: state_next = ST_MEASURE;
      ST_MEASURE:
        if (esc_held)
          state_next = ST_MENU;
        else if (KEYS.reset)
          state_next = ST_CONFIRM;
        else if (KEYS.up)
          state_next = ST_QUICK;
      ST_CONFIRM:
        if (KEYS.enter || KEYS.esc)
          state_next = ST_MEASURE;
      ST_QUICK:
        if (KEYS.esc || timer_reg >= 32'(QUICK_CYC - 1))
          state_next = ST_MEASURE;
      ST_MENU:
        if (KEYS.enter)
          state_next = ST_EDIT;
        else if (KEYS.esc && !esc_held)
          state_next = ST_MEASURE;
      ST_EDIT:
        if (KEYS.enter || KEYS.esc)
          state_next = ST_MENU;
      default: state_next = ST_MEASURE;
    endcase
  end

  // ****************************************************************
  // Sequencing flops
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= ST_ID;
      timer_reg <= 32'h0;
      hold_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != state_reg || (state_reg == ST_QUICK && quick_step))
        timer_reg <= 32'h0;
      else
        timer_reg <= timer_reg + 32'h1;
      if (!KEYS.esc)
        hold_reg <= 32'h0;
      else if (!esc_held)
        hold_reg <= hold_reg + 32'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      item_reg <= 2'h0;
      alt_reg <= 32'h0;
      name_reg <= 1'b1;
      edit_reg <= 32'h0;
    end
    else
    begin
      if (state_reg == ST_MEASURE)
        item_reg <= first_item;
      else if (state_reg == ST_QUICK && quick_step)
        item_reg <= item_next;
      if (state_reg != ST_QUICK || quick_step || alt_reg >= 32'(`SPQC_ALT_CYC - 1))
        alt_reg <= 32'h0;
      else
        alt_reg <= alt_reg + 32'h1;
      if (state_reg != ST_QUICK || quick_step)
        name_reg <= 1'b1;
      else if (alt_reg >= 32'(`SPQC_ALT_CYC - 1))
        name_reg <= !name_reg;
      if (state_reg == ST_MENU)
        edit_reg <= base_reg;
      else if (state_reg == ST_EDIT && KEYS.up)
        edit_reg <= edit_reg + 32'h1;
      else if (state_reg == ST_EDIT && KEYS.down)
        edit_reg <= edit_reg - 32'h1;
    end
  end

  // ****************************************************************
  // Counting and settings
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      raw_reg <= 32'h0;
    end
    else
    begin
      a_reg <= IN_A;
      b_reg <= IN_B;
      raw_reg <= raw_next;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_reg <= `SPQC_CTRL_RST;
      mul_reg <= `SPQC_MUL_RST;
      div_reg <= `SPQC_DIV_RST;
      base_reg <= `SPQC_BASE_RST;
      thr0_reg <= 32'h0;
      thr1_reg <= 32'h0;
      mask_reg <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= BUS.wdata;
      if (wr_mul)
        mul_reg <= BUS.wdata;
      if (wr_div)
        div_reg <= BUS.wdata;
      if (wr_base)
        base_reg <= BUS.wdata;
      else if (edit_commit)
        base_reg <= edit_reg;
      if (wr_thr0)
        thr0_reg <= BUS.wdata;
      if (wr_thr1)
        thr1_reg <= BUS.wdata;
      if (wr_mask)
        mask_reg <= BUS.wdata[`SPQC_STAT_W-1:0];
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      act_mul_reg <= `SPQC_MUL_RST;
      act_div_reg <= `SPQC_DIV_RST;
      act_base_reg <= `SPQC_BASE_RST;
    end
    else if (apply_set)
    begin
      act_mul_reg <= mul_reg;
      act_div_reg <= div_reg;
      act_base_reg <= base_reg;
    end
  end

  // ****************************************************************
  // Status, interrupt and read data
  // ****************************************************************
  logic [`SPQC_STAT_W-1:0] stat_set;
  logic [31:0] rd_next;

  always_comb
  begin
    stat_set = '0;
    stat_set[`SPQC_ST_ZERO] = zero_now;
    stat_set[`SPQC_ST_OVF] = over && !ovf_reg;
    stat_set[`SPQC_ST_UNF] = under && !unf_reg;
    stat_set[`SPQC_ST_MENU] = (state_next == ST_MENU) && (state_reg == ST_MEASURE);
  end

  always_comb
  begin
    case (BUS.addr)
      `SPQC_OFF_CTRL: rd_next = ctrl_reg;
      `SPQC_OFF_MUL: rd_next = mul_reg;
      `SPQC_OFF_DIV: rd_next = div_reg;
      `SPQC_OFF_BASE: rd_next = base_reg;
      `SPQC_OFF_THR0: rd_next = thr0_reg;
      `SPQC_OFF_THR1: rd_next = thr1_reg;
      `SPQC_OFF_RAW: rd_next = raw_reg;
      `SPQC_OFF_RESULT: rd_next = result[31:0];
      `SPQC_OFF_STAT: rd_next = 32'(stat_reg);
      `SPQC_OFF_MASK: rd_next = 32'(mask_reg);
      `SPQC_OFF_VIEW: rd_next = {24'h0, 1'b0, 3'(show_reg), 1'b0, 3'(state_reg)};
      default: rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      stat_reg <= '0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      irq_reg <= 1'b0;
      rd_reg <= 32'h0;
    end
    else
    begin
      stat_reg <= (stat_reg & ~(wr_stat ? BUS.wdata[`SPQC_STAT_W-1:0] : '0)) | stat_set;
      ovf_reg <= over;
      unf_reg <= under;
      irq_reg <= |(stat_reg & mask_reg);
      rd_reg <= BUS.rd ? rd_next : 32'h0;
    end
  end

  // ****************************************************************
  // Display
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      show_reg <= SH_ID;
      disp_reg <= 32'h0;
      menu_reg <= 1'b0;
    end
    else
    begin
      menu_reg <= (state_reg == ST_MENU) || (state_reg == ST_EDIT);
      case (state_reg)
        ST_ID, ST_RESTORE:
        begin
          show_reg <= SH_ID;
          disp_reg <= 32'h0;
        end
        ST_CONFIRM:
        begin
          show_reg <= SH_CONFIRM;
          disp_reg <= 32'h0;
        end
        ST_QUICK:
        begin
          show_reg <= name_reg ? SH_NAME : SH_ITEM;
          disp_reg <= item_value;
        end
        ST_MENU:
        begin
          show_reg <= SH_MENU;
          disp_reg <= base_reg;
        end
        ST_EDIT:
        begin
          show_reg <= SH_MENU;
          disp_reg <= edit_reg;
        end
        default:
        begin
          show_reg <= over ? SH_OVF : under ? SH_UNF : SH_VALUE;
          disp_reg <= result[31:0];
        end
      endcase
    end
  end

  assign RD_DATA = rd_reg;
  assign SHOW = show_reg;
  assign DISP_VALUE = disp_reg;
  assign DISP_ITEM = item_reg;
  assign MENU_OPEN = menu_reg;
  assign IRQ = irq_reg;

endmodule

// >>> verif/spqc_properties.sv
// Purpose: Port-level assertions of the scaled pulse and quadrature counter.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: Bound to spqc_counter from the bench top file.
`timescale 1ns/1ps
`include "spqc_params.svh"

module spqc_properties
  import spqc_pkg::*;
#(
  parameter int QUICK_CYC = 50,
  parameter int HOLD_CYC = 20
) (
  input wire logic CLK,
  input wire logic RST,
  input wire spqc_pkg::spqc_bus_t BUS,
  input wire logic [31:0] RD_DATA,
  input wire logic IN_ZERO,
  input wire spqc_pkg::spqc_keys_t KEYS,
  input wire spqc_pkg::spqc_show_t SHOW,
  input wire logic [31:0] DISP_VALUE,
  input wire logic [1:0] DISP_ITEM,
  input wire logic MENU_OPEN,
  input wire logic IRQ
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic [31:0] start_cnt_reg;
  logic [31:0] quick_cnt_reg;
  logic [31:0] esc_run_reg;
  logic esc_prev_reg;
  wire quick_on = (SHOW == SH_NAME) || (SHOW == SH_ITEM);
  wire quiet = quick_on && !KEYS.up && !KEYS.down;
  wire [31:0] start_cnt_next = (start_cnt_reg < 32'h7d0) ? start_cnt_reg + 32'h1 : start_cnt_reg;
  wire [31:0] quick_cnt_next = quiet ? quick_cnt_reg + 32'h1 : 32'h0;
  wire [31:0] esc_step = esc_prev_reg ? esc_run_reg + 32'h1 : 32'h1;
  wire [31:0] esc_run_next = KEYS.esc ? esc_step : esc_run_reg;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      start_cnt_reg <= 32'h0;
      quick_cnt_reg <= 32'h0;
      esc_run_reg <= 32'h0;
      esc_prev_reg <= 1'b0;
    end
    else
    begin
      start_cnt_reg <= start_cnt_next;
      quick_cnt_reg <= quick_cnt_next;
      esc_run_reg <= esc_run_next;
      esc_prev_reg <= KEYS.esc;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_read_idle_zero: assert property (!$past(BUS.rd) |-> RD_DATA == 32'h0)
    else $error("read data not zero outside the read answer cycle");
  a_unmapped_read: assert property (BUS.rd && BUS.addr > 4'hb |=> RD_DATA == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_id_at_start: assert property (start_cnt_reg < 32'h3d6 |-> SHOW == SH_ID)
    else $error("identity not shown right after reset");
  a_show_in_range: assert property (SHOW == SH_VALUE |->
    $signed(DISP_VALUE) <= 999999 && $signed(DISP_VALUE) >= -99999)
    else $error("numeric result shown outside the display range");
  a_menu_after_hold: assert property ($rose(MENU_OPEN) |-> esc_run_reg >= HOLD_CYC - 3)
    else $error("menu opened without a long escape hold");
  a_quick_timeout: assert property (quick_cnt_reg <= QUICK_CYC + 4)
    else $error("quick view outlived its timeout");
  a_item_in_range: assert property (quick_on |-> DISP_ITEM <= 2'h2)
    else $error("quick view item out of range");
  a_first_item: assert property ($rose(quick_on) |=> DISP_ITEM <= 2'h1)
    else $error("quick view did not start at base or first threshold");
  a_zero_holds: assert property ($past(IN_ZERO) && $past(IN_ZERO, 2) && $past(IN_ZERO, 3) &&
    SHOW == SH_VALUE && $past(SHOW) == SH_VALUE |-> $stable(DISP_VALUE))
    else $error("shown value moved while zero input held");
  a_irq_mask_off: assert property (BUS.wr && BUS.addr == `SPQC_OFF_MASK &&
    BUS.wdata == 32'h0 |-> ##2 !IRQ)
    else $error("interrupt stayed high after full masking");
endmodule

// >>> verif/spqc_encoder.sv
// Purpose: Pulse sensor and quadrature encoder on the counting inputs.
// Assumes: Tasks are entered just after a rising edge of clk.
// Notes: Lines keep their last level between steps, as a real sensor does.
`timescale 1ns/1ps

module spqc_encoder (
  input wire logic clk,
  output logic out_a,
  output logic out_b
);
  // ****************************************************************
  // Drive tasks
  // ****************************************************************
  initial
  begin
    out_a = 1'b0;
    out_b = 1'b0;
  end

  // Gives one pulse on A or B; each level stands gap cycles.
  task automatic pulse(input logic on_b, input int gap);
    if (on_b)
      out_b <= 1'b1;
    else
      out_a <= 1'b1;
    repeat (gap) @(posedge clk);
    out_a <= 1'b0;
    out_b <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask

  // Walks the phase code one edge per step; forward means A leads B.
  task automatic quad(input int steps, input logic fwd, input int gap);
    logic a;
    for (int k = 0; k < steps; k++)
    begin
      a = out_a;
      out_a <= fwd ? ~out_b : out_b;
      out_b <= fwd ? a : ~a;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule

// >>> verif/tb_scaled_pulse_quadrature_counter.sv
// Purpose: Self-checking bench of the scaled pulse and quadrature counter.
// Assumes: Short quick view and menu hold counts for simulation.
// Notes: Register reads are queued and compared in their answer cycle.
`timescale 1ns/1ps
`include "spqc_params.svh"

module tb_scaled_pulse_quadrature_counter;
  import spqc_pkg::*;
  localparam int QC = 3000;
  localparam int HC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  spqc_bus_t bus = '0;
  spqc_keys_t keys = '0;
  logic in_aux = 1'b0;
  logic in_zero = 1'b0;
  logic nv_valid = 1'b1;
  logic [31:0] nv_count = 32'h0;
  logic in_a, in_b, menu_open, irq, rd_d = 1'b0;
  logic [31:0] rd_data, disp_value;
  logic [1:0] disp_item;
  spqc_show_t show;
  logic [35:0] rq[$];
  logic [35:0] note;
  logic [31:0] exp_f [4] = '{32'h5, 32'h1, 32'h1, 32'h4};
  int fail_count = 0;
  int cmp_count = 0;
  int i, n, m, d, b;

  always #12.5 clk = ~clk;

  spqc_counter #(.QUICK_CYC(QC), .HOLD_CYC(HC)) dut (.CLK(clk), .RST(rst), .BUS(bus),
    .RD_DATA(rd_data), .IN_A(in_a), .IN_B(in_b), .IN_AUX(in_aux), .IN_ZERO(in_zero),
    .KEYS(keys), .NV_VALID(nv_valid), .NV_COUNT(nv_count), .SHOW(show),
    .DISP_VALUE(disp_value), .DISP_ITEM(disp_item), .MENU_OPEN(menu_open), .IRQ(irq));
  spqc_encoder enc (.clk(clk), .out_a(in_a), .out_b(in_b));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic int gap();
    return $urandom_range(1, 3);
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rq.push_back({a, exp});
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic press(input logic [4:0] k, input int len);
    keys <= k;
    repeat (len) @(posedge clk);
    keys <= '0;
    @(posedge clk);
  endtask

  task automatic see(input spqc_show_t s, input int lim);
    @(negedge clk);
    for (int k = 0; k < lim && show !== s; k++)
      @(negedge clk);
    chk("show", s, show);
    @(posedge clk);
  endtask

  task automatic look(input string what, input int sel, input logic [31:0] exp);
    @(negedge clk);
    case (sel)
      0: chk(what, exp, disp_value);
      1: chk(what, exp, {31'h0, irq});
      2: chk(what, exp, {30'h0, disp_item});
      default: chk(what, exp, {31'h0, menu_open});
    endcase
    @(posedge clk);
  endtask

  // Compares each read answer with the oldest queued expectation.
  always @(posedge clk)
  begin
    rd_d <= bus.rd;
    if (rd_d)
    begin
      note = rq.pop_front();
      chk($sformatf("reg %h", note[35:32]), note[31:0], rd_data);
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h38b49df8));
    n = $urandom_range(1, 500);
    nv_count = n;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (1010) @(posedge clk);
    see(SH_VALUE, 20);
    rd(`SPQC_OFF_RAW, n);
    rd(`SPQC_OFF_CTRL, `SPQC_CTRL_RST);
    rd(`SPQC_OFF_MUL, `SPQC_MUL_RST);
    rd(`SPQC_OFF_DIV, `SPQC_DIV_RST);
    rd(`SPQC_OFF_BASE, `SPQC_BASE_RST);
    rd(4'hf, 32'h0);
    wr(`SPQC_OFF_RAW, 32'h55);
    rd(`SPQC_OFF_RAW, n);
    $display("test power-up done");
    for (i = 0; i < 4; i++)
    begin
      wr(`SPQC_OFF_CTRL, 32'h4 | i);
      wr(`SPQC_OFF_PRESET, 32'h0);
      if (i < 2)
      begin
        repeat (3) enc.pulse(1'b0, gap());
        repeat (2) enc.pulse(1'b1, gap());
      end
      else
      begin
        enc.quad(8, 1'b1, gap());
        enc.quad(4, 1'b0, gap());
      end
      rd(`SPQC_OFF_RAW, exp_f[i]);
    end
    wr(`SPQC_OFF_CTRL, 32'hc);
    wr(`SPQC_OFF_PRESET, 32'h0);
    in_aux <= 1'b1;
    repeat (2) enc.pulse(1'b0, gap());
    in_aux <= 1'b0;
    enc.pulse(1'b0, gap());
    rd(`SPQC_OFF_RAW, 32'hffff_ffff);
    $display("test counting functions done");
    for (i = 0; i < 4; i++)
    begin
      m = $urandom_range(1, 100);
      d = $urandom_range(1, 7);
      b = $urandom_range(0, 100) - 50;
      n = $urandom_range(1, 6);
      wr(`SPQC_OFF_CTRL, 32'h4);
      wr(`SPQC_OFF_MUL, m);
      wr(`SPQC_OFF_DIV, d);
      wr(`SPQC_OFF_BASE, b);
      wr(`SPQC_OFF_PRESET, 32'h0);
      rd(`SPQC_OFF_RESULT, b);
      repeat (n) enc.pulse(1'b0, gap());
      rd(`SPQC_OFF_RESULT, n * m / d + b);
    end
    wr(`SPQC_OFF_MUL, 32'h1);
    wr(`SPQC_OFF_DIV, 32'h1);
    wr(`SPQC_OFF_MASK, 32'h6);
    wr(`SPQC_OFF_BASE, 32'h000f_423f);
    wr(`SPQC_OFF_PRESET, 32'h0);
    see(SH_VALUE, 4);
    look("value", 0, 32'h000f_423f);
    enc.pulse(1'b0, 1);
    see(SH_OVF, 4);
    repeat (2) @(posedge clk);
    look("irq", 1, 32'h1);
    rd(`SPQC_OFF_STAT, 32'h3);
    wr(`SPQC_OFF_STAT, 32'h3);
    look("irq", 1, 32'h0);
    wr(`SPQC_OFF_CTRL, 32'h5);
    wr(`SPQC_OFF_BASE, 32'hfffe_7961);
    wr(`SPQC_OFF_PRESET, 32'h0);
    see(SH_VALUE, 4);
    look("value", 0, 32'hfffe_7961);
    enc.pulse(1'b1, 1);
    see(SH_UNF, 4);
    repeat (2) @(posedge clk);
    look("irq", 1, 32'h1);
    rd(`SPQC_OFF_STAT, 32'h5);
    wr(`SPQC_OFF_STAT, 32'hf);
    wr(`SPQC_OFF_MASK, 32'h0);
    $display("test scaling and limits done");
    wr(`SPQC_OFF_BASE, 32'h0);
    wr(`SPQC_OFF_CTRL, 32'h0);
    wr(`SPQC_OFF_MUL, 32'h5);
    wr(`SPQC_OFF_BASE, 32'h7);
    rd(`SPQC_OFF_RESULT, 32'hffff_ffff);
    in_zero <= 1'b1;
    repeat (5) @(posedge clk);
    in_zero <= 1'b0;
    rd(`SPQC_OFF_RESULT, 32'h7);
    enc.pulse(1'b0, 2);
    rd(`SPQC_OFF_RESULT, 32'hc);
    press(5'h01, 1);
    see(SH_CONFIRM, 2);
    rd(`SPQC_OFF_RAW, 32'h1);
    press(5'h08, 1);
    rd(`SPQC_OFF_RESULT, 32'h7);
    $display("test zeroing and policy done");
    n = $urandom_range(1, 999);
    wr(`SPQC_OFF_THR0, n);
    wr(`SPQC_OFF_THR1, n + 1);
    press(5'h04, 1);
    see(SH_NAME, 4);
    look("item", 2, 32'h1);
    see(SH_ITEM, 2100);
    look("value", 0, n);
    press(5'h02, 1);
    look("item", 2, 32'h2);
    see(SH_VALUE, QC + 20);
    wr(`SPQC_OFF_CTRL, 32'h10);
    for (i = 0; i < 4; i++)
    begin
      press(5'h04, 1);
      look("item", 2, (i == 3) ? 32'h0 : i);
    end
    see(SH_ITEM, 2100);
    look("value", 0, 32'h7);
    press(5'h10, 1);
    see(SH_VALUE, 4);
    $display("test quick view done");
    wr(`SPQC_OFF_CTRL, 32'h0);
    press(5'h10, 10);
    look("menu", 3, 32'h0);
    press(5'h10, HC + 10);
    look("menu", 3, 32'h1);
    rd(`SPQC_OFF_STAT, 32'h9);
    repeat (3) enc.pulse(1'b0, gap());
    rd(`SPQC_OFF_RAW, 32'h3);
    press(5'h08, 1);
    press(5'h04, 1);
    press(5'h10, 1);
    rd(`SPQC_OFF_BASE, 32'h7);
    look("menu", 3, 32'h1);
    press(5'h08, 1);
    press(5'h04, 1);
    press(5'h08, 1);
    rd(`SPQC_OFF_BASE, 32'h8);
    press(5'h10, 1);
    look("menu", 3, 32'h0);
    $display("test menu done");
    stop_test();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule

bind spqc_counter spqc_properties #(.QUICK_CYC(QUICK_CYC), .HOLD_CYC(HOLD_CYC)) u_props (
  .CLK(CLK), .RST(RST), .BUS(BUS), .RD_DATA(RD_DATA), .IN_ZERO(IN_ZERO), .KEYS(KEYS),
  .SHOW(SHOW), .DISP_VALUE(DISP_VALUE), .DISP_ITEM(DISP_ITEM), .MENU_OPEN(MENU_OPEN),
  .IRQ(IRQ));
